// ==== hdl/fps_pkg.sv ====
// package for the flash program sequencer host controller
package fps_pkg;
	localparam int ADDR_W = 22;
	localparam int DATA_W = 16;
	localparam int BUF_WORDS = 16;
	localparam int PAGE_LSB = 4;
	// command encodings fixed as package localparams; no parameter overrides them
	localparam logic [ADDR_W-1:0] UNLOCK1_ADDR = 22'h000555;
	localparam logic [ADDR_W-1:0] UNLOCK2_ADDR = 22'h0002AA;
	localparam logic [DATA_W-1:0] UNLOCK1_DATA = 16'h00AA;
	localparam logic [DATA_W-1:0] UNLOCK2_DATA = 16'h0055;
	localparam logic [DATA_W-1:0] PROG_SETUP = 16'h00A0;
	localparam logic [DATA_W-1:0] BYPASS_ENTER = 16'h0020;
	localparam logic [DATA_W-1:0] BYPASS_PROG = 16'h00A0;
	localparam logic [DATA_W-1:0] BYPASS_EXIT1 = 16'h0090;
	localparam logic [DATA_W-1:0] BYPASS_EXIT2 = 16'h0000;
	localparam logic [DATA_W-1:0] BUF_LOAD = 16'h0025;
	localparam logic [DATA_W-1:0] BUF_CONFIRM = 16'h0029;
	localparam logic [DATA_W-1:0] BUF_ABORT_RST = 16'h00F0;
	localparam logic [DATA_W-1:0] SEC_ENTER = 16'h0088;
	localparam logic [DATA_W-1:0] SEC_EXIT1 = 16'h0090;
	localparam logic [DATA_W-1:0] SEC_EXIT2 = 16'h0000;
	// bus timing in ns and derived cycle counts at 100 MHz
	localparam int CLK_NS = 10;
	localparam int T_STROBE_NS = 40;
	localparam int T_SETUP_NS = 20;
	localparam int STROBE_CYC = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
	localparam int SETUP_CYC = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
	// status bit positions
	localparam int ST_POLL = 7;
	localparam int ST_TOGGLE = 6;
	localparam int ST_FAIL = 5;
	localparam int ST_ABORT = 1;
	typedef enum logic [2:0] {
		FPS_OP_PROG,
		FPS_OP_BYP_ENTER,
		FPS_OP_BYP_PROG,
		FPS_OP_BYP_EXIT,
		FPS_OP_BUF_PROG,
		FPS_OP_SEC_ENTER,
		FPS_OP_SEC_EXIT,
		FPS_OP_ABORT_RST
	} fps_op_t;
	typedef struct packed {
		fps_op_t op;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} fps_req_t;
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dq_o;
		logic dq_oe;
		logic ce_n;
		logic we_n;
		logic oe_n;
	} fps_bus_t;
endpackage : fps_pkg

// ==== hdl/fps_host.sv ====
// host controller that sequences program commands into a parallel nor flash
// Notes on behaviour
// - secure region entered by three writes; stays until exit sequence
// - four-write exit sequence leaves secure region
// - standard program: two unlocks, setup, then address and data
// - completion found by polling status bit 6 until it stops toggling; bit 7 is not read
// - bypass entered by two unlocks plus bypass code
// - bypass program is two writes: code then address and data
// - bypass exit writes 90h then 00h
// - buffer program: unlocks, load at sector, count minus one, max 16
// - confirm at sector address after loads; anything else aborts
// - host polls last loaded address watching bits 6,5,1
// - abort shows bit1 high; host then issues abort reset
// - abort reset is full three writes even in bypass
// - address latched on falling strobe, data on rising strobe
`timescale 1ns/1ns
module fps_host (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic req_valid,
	input fps_pkg::fps_req_t req,
	input wire logic [fps_pkg::DATA_W-1:0] buf_data [fps_pkg::BUF_WORDS],
	input wire logic [fps_pkg::CNT_W-1:0] buf_count_m1,
	input wire logic accel_req,
	output logic req_ready,
	output logic done,
	output logic fail,
	output logic aborted,
	output logic in_bypass,
	output logic in_secure,
	output logic protect_accel_pin,
	output fps_pkg::fps_bus_t bus,
	input wire logic [fps_pkg::DATA_W-1:0] dq_i
);
	import fps_pkg::*;
	typedef enum {S_IDLE, S_WRITE, S_GAP, S_POLL1, S_POLL2, S_FIN} fps_state_t;
	fps_state_t state_ff;
	logic [3:0] step_ff;
	logic [CNT_W-1:0] idx_ff;
	logic [3:0] tcnt_ff;
	logic rd_ff;
	logic err_ff;
	fps_req_t cur_ff;
	logic [DATA_W-1:0] dq_s1_ff, dq_s2_ff, prev_ff;
	logic [ADDR_W-1:0] wa;
	logic [DATA_W-1:0] wd;
	logic last_w, polls;

	// synchronise read data from the device
	always_ff @(posedge clk_sys) begin
		dq_s1_ff <= dq_i;
		dq_s2_ff <= dq_s1_ff;
	end

	// address/data of the current write step
	always_comb begin
		wa = UNLOCK1_ADDR;
		wd = UNLOCK1_DATA;
		last_w = 1'b0;
		polls = 1'b0;
		case (cur_ff.op)
			FPS_OP_PROG: begin
				polls = 1'b1;
				last_w = (step_ff == 4'h3);
				case (step_ff)
					4'h0: begin wa = UNLOCK1_ADDR; wd = UNLOCK1_DATA; end
					4'h1: begin wa = UNLOCK2_ADDR; wd = UNLOCK2_DATA; end
					4'h2: begin wa = UNLOCK1_ADDR; wd = PROG_SETUP; end
					default: begin wa = cur_ff.addr; wd = cur_ff.data; end
				endcase
			end
			FPS_OP_BYP_ENTER, FPS_OP_SEC_ENTER: begin
				last_w = (step_ff == 4'h2);
				case (step_ff)
					4'h0: begin wa = UNLOCK1_ADDR; wd = UNLOCK1_DATA; end
					4'h1: begin wa = UNLOCK2_ADDR; wd = UNLOCK2_DATA; end
					default: begin
						wa = UNLOCK1_ADDR;
						wd = (cur_ff.op == FPS_OP_SEC_ENTER) ? SEC_ENTER : BYPASS_ENTER;
					end
				endcase
			end
			FPS_OP_BYP_PROG: begin
				polls = 1'b1;
				last_w = (step_ff == 4'h1);
				wa = (step_ff == 4'h0) ? UNLOCK1_ADDR : cur_ff.addr;
				wd = (step_ff == 4'h0) ? BYPASS_PROG : cur_ff.data;
			end
			FPS_OP_BYP_EXIT: begin
				last_w = (step_ff == 4'h1);
				wa = cur_ff.addr;
				wd = (step_ff == 4'h0) ? BYPASS_EXIT1 : BYPASS_EXIT2;
			end
			FPS_OP_SEC_EXIT: begin
				last_w = (step_ff == 4'h3);
				case (step_ff)
					4'h0: begin wa = UNLOCK1_ADDR; wd = UNLOCK1_DATA; end
					4'h1: begin wa = UNLOCK2_ADDR; wd = UNLOCK2_DATA; end
					4'h2: begin wa = UNLOCK1_ADDR; wd = SEC_EXIT1; end
					default: begin wa = cur_ff.addr; wd = SEC_EXIT2; end
				endcase
			end
			FPS_OP_ABORT_RST: begin
				last_w = (step_ff == 4'h2);
				case (step_ff)
					4'h0: begin wa = UNLOCK1_ADDR; wd = UNLOCK1_DATA; end
					4'h1: begin wa = UNLOCK2_ADDR; wd = UNLOCK2_DATA; end
					default: begin wa = UNLOCK1_ADDR; wd = BUF_ABORT_RST; end
				endcase
			end
			default: begin // buffered program
				polls = 1'b1;
				case (step_ff)
					4'h0: begin wa = UNLOCK1_ADDR; wd = UNLOCK1_DATA; end
					4'h1: begin wa = UNLOCK2_ADDR; wd = UNLOCK2_DATA; end
					4'h2: begin wa = cur_ff.addr; wd = BUF_LOAD; end
					4'h3: begin wa = cur_ff.addr; wd = {{(DATA_W-CNT_W){1'b0}}, cur_ff.data[CNT_W-1:0]}; end
					4'h4: begin
						// loads stay within one page: only low bits vary
						wa = {cur_ff.addr[ADDR_W-1:PAGE_LSB], idx_ff};
						wd = buf_data[idx_ff];
					end
					default: begin wa = cur_ff.addr; wd = BUF_CONFIRM; last_w = 1'b1; end
				endcase
			end
		endcase
	end

	// command sequencing and strobe timing
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state_ff <= S_IDLE;
			step_ff <= 4'h0;
			idx_ff <= CNT_ZERO;
			tcnt_ff <= 4'h0;
			rd_ff <= 1'b0;
			err_ff <= 1'b0;
			cur_ff <= '0;
			prev_ff <= '0;
			req_ready <= 1'b0;
			done <= 1'b0;
			fail <= 1'b0;
			aborted <= 1'b0;
			bus <= '{addr: '0, dq_o: '0, dq_oe: 1'b0, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1};
		end else begin
			done <= 1'b0;
			case (state_ff)
				S_IDLE: begin
					req_ready <= 1'b1;
					if (req_valid && req_ready) begin
						req_ready <= 1'b0;
						cur_ff <= req;
						// host never asks for more than the buffer holds
						if (req.op == FPS_OP_BUF_PROG)
							cur_ff.data <= {{(DATA_W-CNT_W){1'b0}}, buf_count_m1};
						step_ff <= 4'h0;
						idx_ff <= CNT_ZERO;
						tcnt_ff <= 4'h0;
						rd_ff <= 1'b0;
						err_ff <= 1'b0;
						fail <= 1'b0;
						state_ff <= S_WRITE;
					end
				end
				S_WRITE: begin // address set before we_n falls, data held past rise
					bus.addr <= wa;
					bus.dq_o <= wd;
					bus.dq_oe <= 1'b1;
					bus.oe_n <= 1'b1;
					bus.ce_n <= 1'b0;
					tcnt_ff <= tcnt_ff + 4'h1;
					if (tcnt_ff == 4'(SETUP_CYC))
						bus.we_n <= 1'b0;
					if (tcnt_ff == 4'(SETUP_CYC + STROBE_CYC)) begin
						bus.we_n <= 1'b1;
						tcnt_ff <= 4'h0;
						state_ff <= S_GAP;
					end
				end
				S_GAP: begin
					bus.ce_n <= 1'b1;
					if (last_w) begin
						if (cur_ff.op == FPS_OP_ABORT_RST)
							aborted <= 1'b0;
						state_ff <= polls ? S_POLL1 : S_FIN;
						bus.dq_oe <= 1'b0;
					end else begin
						state_ff <= S_WRITE;
						if (cur_ff.op == FPS_OP_BUF_PROG && step_ff == 4'h4) begin
							// every load counts idx_ff up until it equals the count
							if (idx_ff != cur_ff.data[CNT_W-1:0])
								idx_ff <= idx_ff + 4'h1;
							else
								step_ff <= 4'h5;
						end else
							step_ff <= step_ff + 4'h1;
					end
				end
				S_POLL1: begin // read status at last loaded address
					bus.dq_oe <= 1'b0;
					bus.ce_n <= 1'b0;
					bus.oe_n <= 1'b0;
					if (cur_ff.op == FPS_OP_BUF_PROG)
						bus.addr <= {cur_ff.addr[ADDR_W-1:PAGE_LSB], idx_ff};
					tcnt_ff <= tcnt_ff + 4'h1;
					if (tcnt_ff == 4'(STROBE_CYC + 2)) begin
						tcnt_ff <= 4'h0;
						rd_ff <= 1'b1;
						bus.oe_n <= 1'b1;
						bus.ce_n <= 1'b1;
						state_ff <= S_POLL2;
						prev_ff <= dq_s2_ff;
						// toggle beside an error bit may be the last one: confirm on next read
						if (rd_ff) begin
							err_ff <= 1'b0;
							if (dq_s2_ff[ST_TOGGLE] == prev_ff[ST_TOGGLE])
								state_ff <= S_FIN;
							else if (err_ff && dq_s2_ff[ST_ABORT]) begin
								aborted <= 1'b1;
								fail <= 1'b1;
								state_ff <= S_FIN;
							end else if (err_ff && dq_s2_ff[ST_FAIL]) begin
								fail <= 1'b1;
								state_ff <= S_FIN;
							end else if (dq_s2_ff[ST_ABORT] || dq_s2_ff[ST_FAIL])
								err_ff <= 1'b1;
						end
					end
				end
				S_POLL2: begin
					// one idle cycle so every status read is a fresh output-enable pulse
					state_ff <= S_POLL1;
				end
				default: begin
					done <= 1'b1;
					state_ff <= S_IDLE;
				end
			endcase
		end
	end

	// mode tracking of the device as seen by the host
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			in_bypass <= 1'b0;
			in_secure <= 1'b0;
			protect_accel_pin <= 1'b0;
		end else begin
			protect_accel_pin <= accel_req;
			if (state_ff == S_GAP && last_w) begin
				if (cur_ff.op == FPS_OP_BYP_ENTER)
					in_bypass <= 1'b1;
				if (cur_ff.op == FPS_OP_BYP_EXIT)
					in_bypass <= 1'b0;
				if (cur_ff.op == FPS_OP_SEC_ENTER)
					in_secure <= 1'b1;
				if (cur_ff.op == FPS_OP_SEC_EXIT)
					in_secure <= 1'b0;
			end
		end
	end

	property p_strobe_gap;
		@(posedge clk_sys) disable iff (srst)
		$rose(bus.we_n) |-> bus.dq_oe && !bus.ce_n;
	endproperty
	a_strobe_gap: assert property (p_strobe_gap) else $error("data not held at strobe rise");
	property p_we_len;
		@(posedge clk_sys) disable iff (srst)
		$fell(bus.we_n) |-> !bus.we_n [*4];
	endproperty
	a_we_len: assert property (p_we_len) else $error("write strobe too short");
	property p_no_overlap;
		@(posedge clk_sys) disable iff (srst)
		!bus.oe_n |-> bus.we_n && !bus.dq_oe;
	endproperty
	a_no_overlap: assert property (p_no_overlap) else $error("read overlaps write");
	property p_done_pulse;
		@(posedge clk_sys) disable iff (srst)
		done |=> !done;
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done not one cycle");
	property p_byp_set;
		@(posedge clk_sys) disable iff (srst)
		(state_ff == S_GAP && last_w && cur_ff.op == FPS_OP_BYP_ENTER) |=> in_bypass;
	endproperty
	a_byp_set: assert property (p_byp_set) else $error("bypass mode not tracked");
	property p_sec_clr;
		@(posedge clk_sys) disable iff (srst)
		(state_ff == S_GAP && last_w && cur_ff.op == FPS_OP_SEC_EXIT) |=> !in_secure;
	endproperty
	a_sec_clr: assert property (p_sec_clr) else $error("secure exit not tracked");
	property p_abort_clr;
		@(posedge clk_sys) disable iff (srst)
		(state_ff == S_GAP && last_w && cur_ff.op == FPS_OP_ABORT_RST) |=> !aborted;
	endproperty
	a_abort_clr: assert property (p_abort_clr) else $error("abort not cleared");
	property p_buf_page;
		@(posedge clk_sys) disable iff (srst)
		(state_ff == S_WRITE && cur_ff.op == FPS_OP_BUF_PROG && step_ff == 4'h4)
			|-> wa[ADDR_W-1:PAGE_LSB] == cur_ff.addr[ADDR_W-1:PAGE_LSB];
	endproperty
	a_buf_page: assert property (p_buf_page) else $error("load outside page");
	c_prog: cover property (@(posedge clk_sys) cur_ff.op == FPS_OP_PROG && done);
	c_buf: cover property (@(posedge clk_sys) cur_ff.op == FPS_OP_BUF_PROG && done);
	c_abort: cover property (@(posedge clk_sys) $rose(aborted));
endmodule : fps_host

// ==== verification/fps_flash.sv ====
// behavioural flash device model answering the host bus
`timescale 1ns/1ns
module fps_flash #(
	parameter int PROG_CYC = 40
) (
	input wire logic clk_sys,
	input fps_pkg::fps_bus_t bus,
	input wire logic accel_pin,
	input wire logic bad_confirm,
	output logic [fps_pkg::DATA_W-1:0] dq
);
	import fps_pkg::*;
	logic [15:0] mem [256];
	logic [15:0] bf [16];
	logic bv [16];
	logic [15:0] junk = 16'h5A5A;
	logic [15:0] last = 16'h0000;
	logic [17:0] pg;
	logic [21:0] sa;
	logic we_q = 1'b1, oe_q = 1'b1, byp = 1'b0, sec = 1'b0, abt = 1'b0, tog = 1'b0;
	int s = 0, n = 0, k = 0, busy = 0;
	initial foreach (mem[i]) mem[i] = 16'hFFFF;
	// released bus shows a pattern that changes every cycle
	assign dq = (!bus.ce_n && !bus.oe_n) ? ((busy > 0 || abt) ?
		{8'h00, ~last[7], tog, 4'h0, abt, 1'b0} : mem[bus.addr[7:0]]) : junk;
	task automatic wr(input logic [21:0] a, input logic [15:0] d);
		case (s)
			0: s = (d == UNLOCK1_DATA) ? 1 : (byp && !abt && d == BYPASS_PROG) ? 3 :
				(byp && d == BYPASS_EXIT1) ? 10 : 0;
			1: s = (d == UNLOCK2_DATA) ? 2 : 0;
			2: begin
				s = 0;
				if (abt) begin
					if (d == BUF_ABORT_RST) abt <= 1'b0;
				end else if (d == PROG_SETUP) s = 3;
				else if (d == BYPASS_ENTER) byp <= 1'b1;
				else if (d == SEC_ENTER) sec <= 1'b1;
				else if (d == SEC_EXIT1 && sec) s = 11;
				else if (d == BUF_LOAD) begin
					s = 4;
					sa = a;
				end
			end
			3: begin
				mem[a[7:0]] <= mem[a[7:0]] & d;
				last <= d;
				busy <= PROG_CYC;
				s = 0;
			end
			4: begin
				n = d;
				k = 0;
				foreach (bv[i]) bv[i] = 1'b0;
				s = (d > 16'h000F) ? 0 : 5;
				if (s == 0) abt <= 1'b1;
			end
			5: begin
				if (k == 0) pg = a[21:4];
				if (a[21:4] != pg) begin
					abt <= 1'b1;
					s = 0;
				end
				bf[a[3:0]] = d;
				bv[a[3:0]] = 1'b1;
				last <= d;
				k++;
				if (s == 5 && k > n) s = 6;
			end
			6: begin
				s = 0;
				if (d == BUF_CONFIRM && a[21:15] == sa[21:15] && !bad_confirm) begin
					foreach (bf[i]) if (bv[i]) mem[{pg[3:0], 4'(i)}] <= mem[{pg[3:0], 4'(i)}] & bf[i];
					busy <= PROG_CYC;
				end else abt <= 1'b1;
			end
			10: begin
				if (d == BYPASS_EXIT2) byp <= 1'b0;
				s = 0;
			end
			default: begin
				if (d == SEC_EXIT2) sec <= 1'b0;
				s = 0;
			end
		endcase
	endtask : wr
	always @(posedge clk_sys) begin
		junk <= ~junk ^ 16'h0101;
		if (oe_q && !bus.oe_n && !bus.ce_n) tog <= ~tog;
		if (!we_q && bus.we_n && !bus.ce_n && busy == 0) wr(bus.addr, bus.dq_o);
		else if (busy > 0) busy <= busy - 1;
		if (accel_pin) byp <= 1'b1;
		we_q = bus.we_n;
		oe_q = bus.oe_n;
	end
endmodule : fps_flash

// ==== verification/fps_host_tb.sv ====
// testbench for the flash program sequencer host
`timescale 1ns/1ns
module fps_host_tb;
	import fps_pkg::*;
	logic clk_sys = 1'b0, srst = 1'b1, req_valid = 1'b0, accel_req = 1'b0, bad_confirm = 1'b0;
	fps_req_t req = '0;
	logic [DATA_W-1:0] buf_data [BUF_WORDS];
	logic [CNT_W-1:0] buf_count_m1 = 4'h0;
	logic req_ready, done, fail, aborted, in_bypass, in_secure, protect_accel_pin;
	fps_bus_t bus;
	logic [DATA_W-1:0] dq_i;
	int fails = 0, checked = 0, cyc = 0;
	initial forever #5 clk_sys = ~clk_sys;
	fps_host u_fps_host (.clk_sys(clk_sys), .srst(srst), .req_valid(req_valid), .req(req),
		.buf_data(buf_data), .buf_count_m1(buf_count_m1), .accel_req(accel_req),
		.req_ready(req_ready), .done(done), .fail(fail), .aborted(aborted),
		.in_bypass(in_bypass), .in_secure(in_secure),
		.protect_accel_pin(protect_accel_pin), .bus(bus), .dq_i(dq_i));
	fps_flash u_fps_flash (.clk_sys(clk_sys), .bus(bus), .accel_pin(protect_accel_pin),
		.bad_confirm(bad_confirm), .dq(dq_i));
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : stop_test
	task automatic chk_bit(input string nm, input logic e, input logic g);
		checked++;
		if (g !== e) begin
			fails++;
			$display("mismatch %s exp %b got %b", nm, e, g);
		end
	endtask : chk_bit
	task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			fails++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask : chk_word
	task automatic run_op(input fps_op_t op, input logic [21:0] a, input logic [15:0] d);
		@(negedge clk_sys);
		req = '{op, a, d};
		req_valid = 1'b1;
		// ready seen high between edges means the next rising edge takes the request
		while (req_ready !== 1'b1) @(negedge clk_sys);
		@(negedge clk_sys);
		req_valid = 1'b0;
		while (done !== 1'b1) @(negedge clk_sys);
	endtask : run_op
	task automatic t_prog;
		run_op(FPS_OP_PROG, 22'h000010, 16'h1234);
		chk_word("mem10", 16'h1234, u_fps_flash.mem[16]);
		chk_bit("fail", 1'b0, fail);
		run_op(FPS_OP_PROG, 22'h000010, 16'h00FF);
		chk_word("mem10 clear only", 16'h0034, u_fps_flash.mem[16]);
	endtask : t_prog
	task automatic t_bypass;
		run_op(FPS_OP_BYP_ENTER, 22'h000000, 16'h0000);
		chk_bit("in_bypass", 1'b1, in_bypass);
		chk_bit("dev bypass", 1'b1, u_fps_flash.byp);
		run_op(FPS_OP_BYP_PROG, 22'h000011, 16'hA5A5);
		run_op(FPS_OP_BYP_PROG, 22'h000012, 16'h0F0F);
		chk_word("mem11", 16'hA5A5, u_fps_flash.mem[17]);
		chk_word("mem12", 16'h0F0F, u_fps_flash.mem[18]);
		run_op(FPS_OP_BYP_EXIT, 22'h000000, 16'h0000);
		chk_bit("in_bypass", 1'b0, in_bypass);
		chk_bit("dev bypass", 1'b0, u_fps_flash.byp);
	endtask : t_bypass
	task automatic t_buf(input logic [21:0] a, input logic [3:0] c);
		buf_count_m1 = c;
		run_op(FPS_OP_BUF_PROG, a, 16'h0000);
		chk_bit("aborted", 1'b0, aborted);
		for (int i = 0; i < 16; i++)
			chk_word("buf mem", (i <= c) ? 16'hB000 + 16'(i) : 16'hFFFF,
				u_fps_flash.mem[a[7:0] + 8'(i)]);
	endtask : t_buf
	task automatic t_abort;
		bad_confirm = 1'b1;
		buf_count_m1 = 4'h1;
		run_op(FPS_OP_BUF_PROG, 22'h000060, 16'h0000);
		chk_bit("aborted", 1'b1, aborted);
		chk_bit("fail", 1'b1, fail);
		chk_word("mem60", 16'hFFFF, u_fps_flash.mem[96]);
		bad_confirm = 1'b0;
		run_op(FPS_OP_ABORT_RST, 22'h000000, 16'h0000);
		chk_bit("aborted", 1'b0, aborted);
		chk_bit("dev abort", 1'b0, u_fps_flash.abt);
		run_op(FPS_OP_PROG, 22'h000061, 16'h6161);
		chk_word("mem61", 16'h6161, u_fps_flash.mem[97]);
	endtask : t_abort
	task automatic t_secure;
		run_op(FPS_OP_SEC_ENTER, 22'h000000, 16'h0000);
		chk_bit("in_secure", 1'b1, in_secure);
		chk_bit("dev secure", 1'b1, u_fps_flash.sec);
		run_op(FPS_OP_SEC_EXIT, 22'h000000, 16'h0000);
		chk_bit("in_secure", 1'b0, in_secure);
		chk_bit("dev secure", 1'b0, u_fps_flash.sec);
	endtask : t_secure
	task automatic t_accel;
		@(negedge clk_sys);
		accel_req = 1'b1;
		repeat (2) @(negedge clk_sys);
		chk_bit("accel pin", 1'b1, protect_accel_pin);
		chk_bit("dev bypass", 1'b1, u_fps_flash.byp);
		accel_req = 1'b0;
		repeat (2) @(negedge clk_sys);
		chk_bit("accel pin", 1'b0, protect_accel_pin);
	endtask : t_accel
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 60000) begin
			fails++;
			stop_test();
		end
	end
	initial begin
		foreach (buf_data[i]) buf_data[i] = 16'hB000 + 16'(i);
		repeat (10) @(negedge clk_sys);
		chk_bit("ready in reset", 1'b0, req_ready);
		chk_bit("we_n in reset", 1'b1, bus.we_n);
		srst = 1'b0;
		t_prog();
		t_bypass();
		t_buf(22'h000020, 4'hF);
		t_buf(22'h000040, 4'h2);
		t_abort();
		t_secure();
		t_accel();
		stop_test();
	end
endmodule : fps_host_tb
